//--- rtl/gdeio_cfg.svh
// constants and behaviour summary for the dual-edge pin logic
// Overview of operation
// - single-edge input is on bit 0; dual: rise sample bit 0, fall bit 1.
// - single-edge output uses bit 0; dual: bit 0 at rise, bit 1 at fall.
// - an unregistered input feeds a bypass to clock, control or ref nets.
// - the fabric drive enable controls the pad buffer and can be registered.
// - output data and drive-enable registers use the launch clock.
// - input capture registers use a separate capture clock.
// - dual-edge mode samples on both edges and moves a 2-bit word.
// - normal dual-edge passes each bit at its own edge, no realignment.
// - resync dual-edge realigns both bits to the rising edge only.
// - resync input holds the fall sample to pair with the next rise.
// - differential-capable pins used single-ended have no dual edge.
// - each registered path can trigger on the rising or falling edge.
// - a registered output can be inverted before it reaches the pad.
// - input and output paths are registered or unregistered apart.
`ifndef GDEIO_CFG_SVH
`define GDEIO_CFG_SVH

`define GDEIO_ADDR_W        12
`define GDEIO_CTRL_OFS      12'h000
`define GDEIO_STAT_OFS      12'h004
`define GDEIO_CTRL_W        10
`define GDEIO_CTRL_RST      10'h000
`define GDEIO_STAT_OVF_BIT  2
`define GDEIO_CNT_W         4
`define GDEIO_WORD_W        2
`define GDEIO_FIFO_DEPTH    8
`define GDEIO_CLK_PERIOD_NS 10

`endif

//--- rtl/gdeio_pkg.sv
// types shared by the dual-edge pin logic
`include "gdeio_cfg.svh"

package gdeio_pkg;

  typedef enum logic [1:0] {
    byp_global_clock_net,
    byp_global_control_net,
    byp_synth,
    byp_cam
  } gdeio_byp_t;

  typedef struct packed {
    gdeio_byp_t byp;
    logic       resync;
    logic       dual;
    logic       out_inv;
    logic       out_neg;
    logic       in_neg;
    logic       oe_reg;
    logic       out_reg;
    logic       in_reg;
  } gdeio_ctrl_t;

  typedef struct packed {
    logic [`GDEIO_CNT_W-1:0] count;
    logic                    oe_drv;
    logic                    ovf;
    logic                    dual;
    logic                    pad;
  } gdeio_stat_t;

endpackage : gdeio_pkg

//--- rtl/gdeio_fifo_if.sv
// valid/ready carrier between the capture logic and the fifo
`timescale 1ns/1ps

interface gdeio_fifo_if #(
  parameter int W  = 2,
  parameter int CW = 4
);
  logic          push_valid;
  logic          push_ready;
  logic [W-1:0]  push_data;
  logic          pop_valid;
  logic          pop_ready;
  logic [W-1:0]  pop_data;
  logic [CW-1:0] count;

  modport fifo (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, count
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data, count
  );
endinterface : gdeio_fifo_if

//--- rtl/gdeio_fifo.sv
// small synchronous fifo for captured input words
`timescale 1ns/1ps
`include "gdeio_cfg.svh"

module gdeio_fifo #(
  parameter int WIDTH = `GDEIO_WORD_W,
  parameter int DEPTH = `GDEIO_FIFO_DEPTH
) (
  input  wire logic  i_clk,    // system clock
  input  wire logic  i_arst_n, // async reset, active low
  gdeio_fifo_if.fifo f         // push and pop sides
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign f.push_ready = (cnt_q != (AW+1)'(DEPTH));
  assign f.pop_valid  = (cnt_q != '0);
  assign f.pop_data   = mem_q[rd_q];
  assign f.count      = cnt_q;
  assign push         = f.push_valid && f.push_ready;
  assign pop          = f.pop_valid && f.pop_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= f.push_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  fifo_no_overrun_a : assert property (cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  fifo_count_track_a : assert property (
    ##1 cnt_q == $past(cnt_q) + (AW+1)'($past(push)) - (AW+1)'($past(pop)))
    else $error("fifo count does not follow push and pop");

endmodule : gdeio_fifo

//--- rtl/gdeio_top.sv
// per-pin dual-edge input, output and drive-enable logic with apb control
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "gdeio_cfg.svh"

module gdeio_top #(
  parameter bit DIFF_CAPABLE = 1'b0,              // pin is a differential one
  parameter int FIFO_DEPTH   = `GDEIO_FIFO_DEPTH  // input word buffer depth
) (
  input  wire logic                     i_clk,            // 100 MHz clock
  input  wire logic                     i_arst_n,         // async reset
  input  wire logic                     i_psel,           // apb select
  input  wire logic                     i_penable,        // apb enable
  input  wire logic                     i_pwrite,         // apb direction
  input  wire logic [`GDEIO_ADDR_W-1:0] i_paddr,          // apb address
  input  wire logic [31:0]              i_pwdata,         // apb write data
  output logic      [31:0]              o_prdata,         // apb read data
  output logic                          o_pready,         // apb ready
  output logic                          o_pslverr,        // apb error
  input  wire logic                     i_capture_clock,  // capture clock
  input  wire logic                     i_launch_clock,   // launch clock
  input  wire logic                     i_pad_in,         // pad level in
  output logic                          o_pad_out,        // pad drive value
  output logic                          o_pad_oe_n,       // pad enable, low
  input  wire logic                     i_fabric_rise_out,// rise/bit0 out
  input  wire logic                     i_fabric_fall_out,// fall/bit1 out
  input  wire logic                     i_fabric_oe,      // drive enable
  output logic                          o_fabric_rise_in, // rise/bit0 in
  output logic                          o_fabric_fall_in, // fall/bit1 in
  output logic                          o_fabric_in_valid,// input word valid
  input  wire logic                     i_fabric_in_ready,// input word taken
  output logic                          o_bypass_input,   // bypass level
  output logic                          o_global_clock_net,      // to global_clock_net
  output logic                          o_global_control_net,    // to global_control_net
  output logic                          o_synth_ref_input,       // to synth
  output logic                          o_camera_link_ref_input  // to cam
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  gdeio_pkg::gdeio_ctrl_t     ctrl_q;
  gdeio_pkg::gdeio_stat_t     stat;
  logic                       dual_on;
  logic                       cap_lvl_q;
  logic                       lch_lvl_q;
  logic                       cap_rise;
  logic                       cap_fall;
  logic                       lch_rise;
  logic                       lch_fall;
  logic                       cap_edge_sel;
  logic                       lch_edge_sel;
  logic                       rise_smp_q;
  logic                       fall_smp_q;
  logic                       push_v;
  logic [`GDEIO_WORD_W-1:0]   push_w;
  logic                       ovf_q;
  logic                       drv_rise_q;
  logic                       drv_fall_q;
  logic                       drv_ph_q;
  logic                       oe_q;
  logic                       pad_val;
  logic                       oe_val;
  logic                       pad_q;
  logic                       pad_oe_n_q;
  logic [31:0]                prdata_q;
  logic                       setup;
  logic                       access;
  logic                       sel_ctrl;
  logic                       sel_stat;
  logic                       wr_ctrl;
  logic                       wr_stat;

  gdeio_fifo_if #(.W(`GDEIO_WORD_W), .CW(CW)) fif ();

  gdeio_fifo #(
    .WIDTH (`GDEIO_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .f        (fif.fifo)
  );

  // ---- apb slave, zero wait states
  assign setup    = i_psel && !i_penable;
  assign access   = i_psel && i_penable;
  assign sel_ctrl = (i_paddr == `GDEIO_CTRL_OFS);
  assign sel_stat = (i_paddr == `GDEIO_STAT_OFS);
  assign wr_ctrl  = access && i_pwrite && sel_ctrl;
  assign wr_stat  = access && i_pwrite && sel_stat;
  assign o_pready  = 1'b1;
  assign o_pslverr = access && !(sel_ctrl || sel_stat);
  assign o_prdata  = prdata_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= gdeio_pkg::gdeio_ctrl_t'(`GDEIO_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_q <= gdeio_pkg::gdeio_ctrl_t'(i_pwdata[`GDEIO_CTRL_W-1:0]);
    end
  end

  // read data latched in the setup cycle, valid in the access cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_q <= '0;
    end else if (setup && !i_pwrite) begin
      if (sel_ctrl) begin
        prdata_q <= 32'(ctrl_q);
      end else if (sel_stat) begin
        prdata_q <= 32'(stat);
      end else begin
        prdata_q <= '0;
      end
    end
  end

  always_comb begin
    stat        = '0;
    stat.pad    = i_pad_in;
    stat.dual   = dual_on;
    stat.ovf    = ovf_q;
    stat.oe_drv = !pad_oe_n_q;
    stat.count  = `GDEIO_CNT_W'(fif.count);
  end

  // lost capture words, write one to clear, a new loss wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovf_q <= 1'b0;
    end else if (push_v && !fif.push_ready) begin
      ovf_q <= 1'b1;
    end else if (wr_stat && i_pwdata[`GDEIO_STAT_OVF_BIT]) begin
      ovf_q <= 1'b0;
    end
  end

  assign dual_on = ctrl_q.dual && !DIFF_CAPABLE;

  // ---- clock edge detection
  // capture clock edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap_lvl_q <= 1'b0;
    end else begin
      cap_lvl_q <= i_capture_clock;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lch_lvl_q <= 1'b0;
    end else begin
      lch_lvl_q <= i_launch_clock;
    end
  end

  assign cap_rise = i_capture_clock && !cap_lvl_q;
  assign cap_fall = !i_capture_clock && cap_lvl_q;
  assign lch_rise = i_launch_clock && !lch_lvl_q;
  assign lch_fall = !i_launch_clock && lch_lvl_q;
  assign cap_edge_sel = ctrl_q.in_neg ? cap_fall : cap_rise;
  assign lch_edge_sel = ctrl_q.out_neg ? lch_fall : lch_rise;

  // ---- input capture registers
  // sample both edges in dual mode, only the selected edge otherwise
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_smp_q <= 1'b0;
      fall_smp_q <= 1'b0;
    end else if (dual_on) begin
      if (cap_rise) begin
        rise_smp_q <= i_pad_in;
      end
      if (cap_fall) begin
        fall_smp_q <= i_pad_in;
      end
    end else if (cap_edge_sel) begin
      rise_smp_q <= i_pad_in;
    end
  end

  // word pushed toward the fabric, bit 1 falling, bit 0 rising
  always_comb begin
    push_v = 1'b0;
    push_w = {1'b0, i_pad_in};
    if (!ctrl_q.in_reg) begin
      push_v = 1'b0;
    end else if (!dual_on) begin
      push_v = cap_edge_sel;
    end else if (cap_rise) begin
      push_v = 1'b1;
      push_w = {fall_smp_q, i_pad_in};
    end else if (cap_fall && !ctrl_q.resync) begin
      push_v = 1'b1;
      push_w = {i_pad_in, rise_smp_q};
    end
  end

  assign fif.push_valid = push_v;
  assign fif.push_data  = push_w;
  assign fif.pop_ready  = ctrl_q.in_reg && i_fabric_in_ready;

  always_comb begin
    if (ctrl_q.in_reg) begin
      o_fabric_in_valid = fif.pop_valid;
      o_fabric_rise_in  = fif.pop_data[0];
      o_fabric_fall_in  = fif.pop_data[1];
    end else begin
      o_fabric_in_valid = 1'b1;
      o_fabric_rise_in  = i_pad_in;
      o_fabric_fall_in  = 1'b0;
    end
  end

  // ---- bypass routing
  // unregistered bypass
  always_comb begin
    o_bypass_input          = !ctrl_q.in_reg && i_pad_in;
    o_global_clock_net      = 1'b0;
    o_global_control_net    = 1'b0;
    o_synth_ref_input       = 1'b0;
    o_camera_link_ref_input = 1'b0;
    unique case (ctrl_q.byp)
      gdeio_pkg::byp_global_clock_net:  o_global_clock_net      = o_bypass_input;
      gdeio_pkg::byp_global_control_net: o_global_control_net    = o_bypass_input;
      gdeio_pkg::byp_synth: o_synth_ref_input       = o_bypass_input;
      gdeio_pkg::byp_cam:   o_camera_link_ref_input = o_bypass_input;
    endcase
  end

  // ---- output data registers
  // launch bits per edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      drv_rise_q <= 1'b0;
      drv_fall_q <= 1'b0;
      drv_ph_q   <= 1'b0;
    end else if (dual_on) begin
      if (lch_rise) begin
        drv_rise_q <= i_fabric_rise_out;
        drv_ph_q   <= 1'b0;
        if (ctrl_q.resync) begin
          drv_fall_q <= i_fabric_fall_out;
        end
      end
      if (lch_fall) begin
        drv_ph_q <= 1'b1;
        if (!ctrl_q.resync) begin
          drv_fall_q <= i_fabric_fall_out;
        end
      end
    end else if (lch_edge_sel) begin
      drv_rise_q <= i_fabric_rise_out;
      drv_ph_q   <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_q <= 1'b0;
    end else if (dual_on ? lch_rise : lch_edge_sel) begin
      oe_q <= i_fabric_oe;
    end
  end

  always_comb begin
    if (ctrl_q.out_reg) begin
      pad_val = ((dual_on && drv_ph_q) ? drv_fall_q : drv_rise_q)
                ^ ctrl_q.out_inv;
    end else begin
      pad_val = i_fabric_rise_out;
    end
    oe_val = ctrl_q.oe_reg ? oe_q : i_fabric_oe;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pad_q      <= 1'b0;
      pad_oe_n_q <= 1'b1;
    end else begin
      pad_q      <= pad_val;
      pad_oe_n_q <= !oe_val;
    end
  end

  assign o_pad_out  = pad_q;
  assign o_pad_oe_n = pad_oe_n_q;

  // ---- checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_single_launch;
    ctrl_q.out_reg && !dual_on && !ctrl_q.out_inv && lch_edge_sel
    ##1 !lch_edge_sel && $stable(ctrl_q);
  endsequence

  sequence s_resync_fall;
    ctrl_q.in_reg && dual_on && ctrl_q.resync && cap_fall;
  endsequence

  in_single_bit0_a : assert property (
    ctrl_q.in_reg && !dual_on && cap_edge_sel
    |-> push_v && push_w == {1'b0, i_pad_in})
    else $error("single edge input not on bit 0");
  out_single_pad_a : assert property (
    s_single_launch |=> o_pad_out == $past(i_fabric_rise_out, 2))
    else $error("pad does not follow launched bit 0");
  bypass_route_a : assert property (
    !ctrl_q.in_reg && ctrl_q.byp == gdeio_pkg::byp_global_clock_net
    |-> o_global_clock_net == i_pad_in && !o_synth_ref_input)
    else $error("bypass not routed to clock net");
  oe_direct_a : assert property (
    !ctrl_q.oe_reg |=> o_pad_oe_n == !$past(i_fabric_oe))
    else $error("pad enable does not follow drive enable");
  oe_reg_hold_a : assert property (
    !lch_rise && !lch_fall |=> $stable(oe_q))
    else $error("drive enable register moved without launch edge");
  fall_sample_a : assert property (
    dual_on && cap_fall |=> fall_smp_q == $past(i_pad_in))
    else $error("falling sample not captured");
  normal_fall_push_a : assert property (
    ctrl_q.in_reg && dual_on && !ctrl_q.resync && cap_fall
    |-> push_v && push_w[1] == i_pad_in)
    else $error("normal mode fall bit not passed at its edge");
  resync_rise_only_a : assert property (
    ctrl_q.in_reg && dual_on && ctrl_q.resync && push_v |-> cap_rise)
    else $error("resync word pushed off the rising edge");
  resync_hold_a : assert property (
    s_resync_fall ##1 !cap_fall [*2]
    |-> fall_smp_q == $past(i_pad_in, 2))
    else $error("resync fall sample not held");
  diff_no_dual_a : assert property (
    DIFF_CAPABLE |-> !dual_on)
    else $error("dual edge active on differential pin");
  edge_polarity_a : assert property (
    ctrl_q.in_reg && !dual_on && ctrl_q.in_neg && cap_rise |-> !push_v)
    else $error("falling edge input took rising edge");
  out_invert_a : assert property (
    ctrl_q.out_reg && ctrl_q.out_inv && !dual_on
    |=> o_pad_out == !$past(drv_rise_q))
    else $error("registered output not inverted");
  in_direct_a : assert property (
    !ctrl_q.in_reg |-> o_fabric_rise_in == i_pad_in && o_fabric_in_valid)
    else $error("unregistered input not direct");
  apb_ctrl_wr_a : assert property (
    wr_ctrl |=> 32'(ctrl_q) == 32'($past(i_pwdata[`GDEIO_CTRL_W-1:0])))
    else $error("control write not stored");

endmodule : gdeio_top

//--- tb/gdeio_fabric_model.sv
// fabric-side model: capture and launch clocks, output data, input consumer
`timescale 1ns/1ps

module gdeio_fabric_model (
  input  wire logic i_clk,      // system clock
  output logic      o_cap_clk,  // capture clock level
  output logic      o_lau_clk,  // launch clock level
  output logic      o_rise_out, // bit 0 out
  output logic      o_fall_out, // bit 1 out
  output logic      o_oe,       // drive enable
  output logic      o_in_ready, // input word taken
  input  wire logic i_rise_in,  // bit 0 in
  input  wire logic i_fall_in,  // bit 1 in
  input  wire logic i_in_valid  // input word valid
);
  initial begin
    o_cap_clk  = 1'b0;
    o_lau_clk  = 1'b0;
    o_rise_out = 1'b0;
    o_fall_out = 1'b0;
    o_oe       = 1'b0;
    o_in_ready = 1'b0;
  end

  task automatic cap_to(input logic lvl);
    @(posedge i_clk);
    o_cap_clk <= lvl;
    repeat (3) @(posedge i_clk);
  endtask : cap_to

  // launch domain data, set ahead of the edge
  task automatic launch_to(input logic lvl, input logic r, input logic f,
                           input logic e);
    @(posedge i_clk);
    o_rise_out <= r;
    o_fall_out <= f;
    o_oe       <= e;
    @(posedge i_clk);
    o_lau_clk <= lvl;
    repeat (5) @(posedge i_clk);
  endtask : launch_to

  task automatic pop(output logic [1:0] w, output logic ok);
    int n;
    ok = 1'b0;
    w  = 2'h0;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (i_in_valid === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    if (ok) begin
      o_in_ready <= 1'b1;
      @(posedge i_clk);
      w = {i_fall_in, i_rise_in};
      o_in_ready <= 1'b0;
    end
  endtask : pop
endmodule : gdeio_fabric_model

//--- tb/gdeio_top_tb.sv
// self-checking bench for the dual-edge pin logic
`timescale 1ns/1ps
`include "gdeio_cfg.svh"

module gdeio_top_tb;
  logic                     i_clk, i_arst_n, psel, penable, pwrite;
  logic [`GDEIO_ADDR_W-1:0] paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic                     pready, pslverr, er, ok, ext_pad, pad_in;
  logic                     pad_out, pad_oe_n, cap_clk, lau_clk, rise_out;
  logic                     fall_out, oe, rise_in, fall_in, in_valid;
  logic                     in_ready, byp, pad_out2;
  logic [3:0]               nets;
  logic [1:0]               w;
  int                       err_total, num_checks;

  // pad wire resolved from the pin's drive enable
  assign pad_in = pad_oe_n ? ext_pad : pad_out;

  gdeio_top dut_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_capture_clock(cap_clk),
    .i_launch_clock(lau_clk), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_pad_oe_n(pad_oe_n), .i_fabric_rise_out(rise_out),
    .i_fabric_fall_out(fall_out), .i_fabric_oe(oe),
    .o_fabric_rise_in(rise_in), .o_fabric_fall_in(fall_in),
    .o_fabric_in_valid(in_valid), .i_fabric_in_ready(in_ready),
    .o_bypass_input(byp), .o_global_clock_net(nets[0]),
    .o_global_control_net(nets[1]), .o_synth_ref_input(nets[2]),
    .o_camera_link_ref_input(nets[3])
  );

  // differential-capable copy of the pin, dual edge must stay off
  gdeio_top #(.DIFF_CAPABLE(1'b1)) dut2_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(), .o_pready(), .o_pslverr(),
    .i_capture_clock(cap_clk), .i_launch_clock(lau_clk),
    .i_pad_in(ext_pad), .o_pad_out(pad_out2), .o_pad_oe_n(),
    .i_fabric_rise_out(rise_out), .i_fabric_fall_out(fall_out),
    .i_fabric_oe(oe), .o_fabric_rise_in(), .o_fabric_fall_in(),
    .o_fabric_in_valid(), .i_fabric_in_ready(1'b0),
    .o_bypass_input(), .o_global_clock_net(),
    .o_global_control_net(), .o_synth_ref_input(),
    .o_camera_link_ref_input()
  );

  gdeio_fabric_model fab_u (
    .i_clk(i_clk), .o_cap_clk(cap_clk), .o_lau_clk(lau_clk),
    .o_rise_out(rise_out), .o_fall_out(fall_out), .o_oe(oe),
    .o_in_ready(in_ready), .i_rise_in(rise_in), .i_fall_in(fall_in),
    .i_in_valid(in_valid)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic conclude();
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic set_ctrl(input logic [9:0] v);
    xfer(1'b1, `GDEIO_CTRL_OFS, {22'h0, v});
  endtask : set_ctrl

  task automatic cap(input logic p, input logic lvl);
    @(posedge i_clk);
    ext_pad <= p;
    fab_u.cap_to(lvl);
  endtask : cap

  task automatic want(input logic [1:0] e);
    fab_u.pop(w, ok);
    chk_bit(ok, 1'b1);
    if (!ok) conclude();
    chk_word({30'h0, w}, {30'h0, e});
  endtask : want

  task automatic t_reset_unmapped();
    xfer(1'b0, `GDEIO_CTRL_OFS, 32'h0);
    chk_word(rd, 32'h0);
    chk_bit(pad_oe_n, 1'b1);
    xfer(1'b1, 12'h008, 32'hffffffff);
    chk_bit(er, 1'b1);
    xfer(1'b0, 12'h008, 32'h0);
    chk_bit(er, 1'b1);
    chk_word(rd, 32'h0);
    xfer(1'b0, `GDEIO_CTRL_OFS, 32'h0);
    chk_word(rd, 32'h0);
  endtask : t_reset_unmapped

  task automatic t_bypass();
    int d;
    ext_pad <= 1'b1;
    for (d = 0; d < 4; d++) begin
      set_ctrl(10'(d << 8));
      repeat (2) @(posedge i_clk);
      chk_word({28'h0, nets}, 32'h1 << d);
      chk_bit(byp, 1'b1);
    end
    set_ctrl(10'h001);
    repeat (2) @(posedge i_clk);
    chk_bit(byp, 1'b0);
  endtask : t_bypass

  task automatic t_output();
    set_ctrl(10'h000);
    fab_u.launch_to(1'b0, 1'b1, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b1);
    chk_bit(pad_oe_n, 1'b0);
    set_ctrl(10'h006);
    fab_u.launch_to(1'b1, 1'b1, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b1);
    chk_bit(pad_oe_n, 1'b0);
    fab_u.launch_to(1'b0, 1'b0, 1'b0, 1'b0);
    chk_bit(pad_out, 1'b1);
    chk_bit(pad_oe_n, 1'b0);
    fab_u.launch_to(1'b1, 1'b0, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b0);
    set_ctrl(10'h026);
    fab_u.launch_to(1'b0, 1'b0, 1'b0, 1'b1);
    fab_u.launch_to(1'b1, 1'b0, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b1);
    set_ctrl(10'h016);
    fab_u.launch_to(1'b0, 1'b1, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b1);
    set_ctrl(10'h046);
    fab_u.launch_to(1'b1, 1'b1, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b1);
    fab_u.launch_to(1'b0, 1'b1, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b0);
    chk_bit(pad_out2, 1'b1);
    set_ctrl(10'h0c6);
    fab_u.launch_to(1'b1, 1'b1, 1'b1, 1'b1);
    fab_u.launch_to(1'b0, 1'b0, 1'b0, 1'b1);
    chk_bit(pad_out, 1'b1);
    xfer(1'b0, `GDEIO_STAT_OFS, 32'h0);
    chk_word(rd & 32'h2, 32'h2);
    set_ctrl(10'h000);
    fab_u.launch_to(1'b0, 1'b0, 1'b0, 1'b0);
    chk_bit(pad_oe_n, 1'b1);
  endtask : t_output

  task automatic t_input();
    set_ctrl(10'h001);
    cap(1'b1, 1'b1);
    cap(1'b0, 1'b0);
    want(2'b01);
    @(posedge i_clk);
    chk_bit(in_valid, 1'b0);
    set_ctrl(10'h009);
    cap(1'b1, 1'b1);
    cap(1'b1, 1'b0);
    want(2'b01);
    @(posedge i_clk);
    chk_bit(in_valid, 1'b0);
    set_ctrl(10'h041);
    cap(1'b1, 1'b1);
    cap(1'b0, 1'b0);
    cap(1'b1, 1'b1);
    cap(1'b1, 1'b0);
    fab_u.pop(w, ok);
    chk_bit(w[0], 1'b1);
    want(2'b01);
    want(2'b01);
    want(2'b11);
    set_ctrl(10'h0c1);
    cap(1'b1, 1'b1);
    cap(1'b1, 1'b0);
    cap(1'b0, 1'b1);
    cap(1'b0, 1'b0);
    cap(1'b1, 1'b1);
    fab_u.pop(w, ok);
    chk_bit(w[0], 1'b1);
    want(2'b10);
    want(2'b01);
    @(posedge i_clk);
    chk_bit(in_valid, 1'b0);
  endtask : t_input

  task automatic t_overflow();
    int i;
    set_ctrl(10'h001);
    cap(1'b0, 1'b0);
    for (i = 0; i < 9; i++) begin
      cap(i[0], 1'b1);
      cap(i[0], 1'b0);
    end
    xfer(1'b0, `GDEIO_STAT_OFS, 32'h0);
    chk_word(rd & 32'hf4, 32'h84);
    xfer(1'b1, `GDEIO_STAT_OFS, 32'h4);
    xfer(1'b0, `GDEIO_STAT_OFS, 32'h0);
    chk_word(rd & 32'h4, 32'h0);
    for (i = 0; i < 8; i++) want({1'b0, i[0]});
    @(posedge i_clk);
    chk_bit(in_valid, 1'b0);
  endtask : t_overflow

  initial begin
    i_arst_n   = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = 32'h0;
    ext_pad    = 1'b0;
    err_total  = 0;
    num_checks = 0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset_unmapped();
    t_bypass();
    t_output();
    t_input();
    t_overflow();
    conclude();
  end
endmodule : gdeio_top_tb
